// [logic/pstb_defines.svh]
// Timing and sizing constants of the peripheral servicing time budget block
`ifndef PSTB_DEFINES_SVH
`define PSTB_DEFINES_SVH
// ==========================================================================
// Clock and tick
`define PSTB_CLK_NS 50
`define PSTB_TICK_NS 100000
`define PSTB_TICK_CYC ((`PSTB_TICK_NS + `PSTB_CLK_NS - 1) / `PSTB_CLK_NS)
// ==========================================================================
// Budget arithmetic
`define PSTB_PCT_NUM 4
`define PSTB_PCT_DEN 100
`define PSTB_MIN_TICKS 1
// ==========================================================================
// Service categories
`define PSTB_NCAT 4
`define PSTB_CAT_UNIT 0
`define PSTB_CAT_PORT 1
`define PSTB_CAT_COMM 2
`define PSTB_CAT_STOR 3
`endif

// [logic/pstb_pkg.sv]
// Types of the peripheral servicing time budget block
package pstb_pkg;
  // ========================================================================
  // Servicing phase sequencer states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_SELECT,
    ST_ALIGN,
    ST_RUN
  } pstb_state_t;
endpackage : pstb_pkg

// [logic/pstb_budget_if.sv]
// Carrier between the sequencer and one budget calculator
`timescale 1ns/1ps
interface pstb_budget_if #(
  parameter int CW = 32,
  parameter int UW = 16
);
  // Inputs of the calculation
  logic [CW-1:0] prevTicks;
  logic uniformEn;
  logic [UW-1:0] uniformTicks;
  logic active;
  // Resulting budget in ticks
  logic [CW-1:0] budget;

  modport calc (
    input prevTicks,
    input uniformEn,
    input uniformTicks,
    input active,
    output budget
  );
  modport user (
    output prevTicks,
    output uniformEn,
    output uniformTicks,
    output active,
    input budget
  );
endinterface : pstb_budget_if

// [logic/pstb_budget_calc.sv]
// Budget calculator for one service category
`timescale 1ns/1ps
`include "pstb_defines.svh"
module pstb_budget_calc #(
  parameter int CW = 32,
  parameter int UW = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Category carrier
  pstb_budget_if.calc bus
);
  logic [CW+1:0] pctProd;
  logic [CW+1:0] pctFull;
  logic [CW-1:0] rawBudget;
  logic [CW-1:0] budget_d;
  logic [CW-1:0] budget_q;

  // ========================================================================
  // Next budget: proportional or uniform, floored, zero when idle
  always_comb begin
    pctProd = {2'b00, bus.prevTicks} * (CW+2)'(`PSTB_PCT_NUM);
    pctFull = pctProd / (CW+2)'(`PSTB_PCT_DEN);
    rawBudget = bus.uniformEn ? CW'(bus.uniformTicks) : pctFull[CW-1:0];
    if (!bus.active) begin
      budget_d = '0;
    end else if (rawBudget < CW'(`PSTB_MIN_TICKS)) begin
      budget_d = CW'(`PSTB_MIN_TICKS);
    end else begin
      budget_d = rawBudget;
    end
  end

  // Registered so the divider stays off the sequencer path
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      budget_q <= '0;
    end else begin
      budget_q <= budget_d;
    end
  end

  assign bus.budget = budget_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_pctBudget;
    (bus.active && !bus.uniformEn &&
     64'(bus.prevTicks) * 64'(`PSTB_PCT_NUM) >= 64'(`PSTB_PCT_DEN)) |=>
      (64'(bus.budget) * 64'(`PSTB_PCT_DEN) <= 64'($past(bus.prevTicks)) * 64'(`PSTB_PCT_NUM)) &&
      ((64'(bus.budget) + 64'd1) * 64'(`PSTB_PCT_DEN) >
       64'($past(bus.prevTicks)) * 64'(`PSTB_PCT_NUM));
  endproperty
  a_pctBudget: assert property (p_pctBudget)
    else $error("proportional budget is not four percent of last cycle");

  property p_uniBudget;
    (bus.active && bus.uniformEn && bus.uniformTicks != '0) |=>
      bus.budget == CW'($past(bus.uniformTicks));
  endproperty
  a_uniBudget: assert property (p_uniBudget)
    else $error("uniform budget differs from configured time");

  property p_floor;
    bus.active |=> bus.budget >= CW'(`PSTB_MIN_TICKS);
  endproperty
  a_floor: assert property (p_floor)
    else $error("active category budget below one tick");

  property p_idleZero;
    !bus.active |=> bus.budget == '0;
  endproperty
  a_idleZero: assert property (p_idleZero)
    else $error("idle category got a nonzero budget");

  c_uniform: cover property (bus.active && bus.uniformEn ##1 bus.budget != '0);
endmodule : pstb_budget_calc

// [logic/pstb_top.sv]
// Peripheral servicing time budget allocator and window sequencer
`timescale 1ns/1ps
`include "pstb_defines.svh"
module pstb_top #(
  parameter int CW = 32,
  parameter int UW = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Cycle sequencing
  input wire logic cycleStart,
  input wire logic servStart,
  input wire logic ioRefresh,
  // Category presence and configuration
  input wire logic [`PSTB_NCAT-1:0] catActive,
  input wire logic [`PSTB_NCAT-1:0] uniformEn,
  input wire logic [`PSTB_NCAT-1:0][UW-1:0] uniformTime,
  // Servicing status
  output logic [`PSTB_NCAT-1:0] svcGrant,
  output logic svcBusy,
  output logic svcDone,
  output logic [CW-1:0] prevCycleTime
);
  localparam int TICK_CYC = `PSTB_TICK_CYC;
  localparam int PW = $clog2(TICK_CYC);
  localparam int NCAT = `PSTB_NCAT;
  localparam int CATW = $clog2(NCAT);

  logic [PW-1:0] presc_d;
  logic [PW-1:0] presc_q;
  logic tick;
  logic [CW-1:0] cycTicks_d;
  logic [CW-1:0] cycTicks_q;
  logic [CW-1:0] prevCycle_d;
  logic [CW-1:0] prevCycle_q;
  logic [CW-1:0] budget [NCAT];
  pstb_pkg::pstb_state_t state_d;
  pstb_pkg::pstb_state_t state_q;
  logic [CATW-1:0] cat_d;
  logic [CATW-1:0] cat_q;
  logic [CW-1:0] win_d;
  logic [CW-1:0] win_q;
  logic [CW-1:0] el_d;
  logic [CW-1:0] el_q;
  logic [NCAT-1:0] grant_d;
  logic [NCAT-1:0] grant_q;
  logic busy_d;
  logic busy_q;
  logic done_d;
  logic done_q;
  logic lastCat;

  // ========================================================================
  // Free-running 0.1 ms tick
  always_comb begin
    tick = (presc_q == PW'(TICK_CYC - 1));
    presc_d = tick ? '0 : presc_q + PW'(1);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      presc_q <= '0;
    end else begin
      presc_q <= presc_d;
    end
  end

  // ========================================================================
  // Cycle time measurement in ticks, saturating
  always_comb begin
    cycTicks_d = cycTicks_q;
    prevCycle_d = prevCycle_q;
    if (cycleStart) begin
      prevCycle_d = cycTicks_q;
      cycTicks_d = tick ? CW'(1) : '0;
    end else if (tick && cycTicks_q != '1) begin
      cycTicks_d = cycTicks_q + CW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      cycTicks_q <= '0;
      prevCycle_q <= '0;
    end else begin
      cycTicks_q <= cycTicks_d;
      prevCycle_q <= prevCycle_d;
    end
  end

  // ========================================================================
  // One calculator per category
  for (genvar g = 0; g < NCAT; g++) begin : gen_cat
    pstb_budget_if #(.CW(CW), .UW(UW)) bIf ();
    assign bIf.prevTicks = prevCycle_q;
    assign bIf.uniformEn = uniformEn[g];
    assign bIf.uniformTicks = uniformTime[g];
    assign bIf.active = catActive[g];
    assign budget[g] = bIf.budget;
    pstb_budget_calc #(.CW(CW), .UW(UW)) uCalc (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .bus(bIf.calc)
    );
  end

  // ========================================================================
  // Window sequencer: categories in fixed order, zero budgets skipped
  always_comb begin
    state_d = state_q;
    cat_d = cat_q;
    win_d = win_q;
    el_d = el_q;
    done_d = 1'b0;
    lastCat = (cat_q == CATW'(NCAT - 1));
    case (state_q)
      pstb_pkg::ST_IDLE: begin
        if (servStart) begin
          cat_d = '0;
          state_d = pstb_pkg::ST_SELECT;
        end
      end
      pstb_pkg::ST_SELECT: begin
        if (budget[cat_q] == '0) begin
          if (lastCat) begin
            state_d = pstb_pkg::ST_IDLE;
            done_d = 1'b1;
          end else begin
            cat_d = cat_q + CATW'(1);
          end
        end else begin
          win_d = budget[cat_q];
          el_d = '0;
          state_d = pstb_pkg::ST_ALIGN;
        end
      end
      // Start on a tick edge so the window is whole ticks long
      pstb_pkg::ST_ALIGN: begin
        if (tick) begin
          state_d = pstb_pkg::ST_RUN;
        end
      end
      pstb_pkg::ST_RUN: begin
        if (tick && !ioRefresh) begin
          el_d = el_q + CW'(1);
          if (el_q + CW'(1) == win_q) begin
            if (lastCat) begin
              state_d = pstb_pkg::ST_IDLE;
              done_d = 1'b1;
            end else begin
              cat_d = cat_q + CATW'(1);
              state_d = pstb_pkg::ST_SELECT;
            end
          end
        end
      end
      default: begin
        state_d = pstb_pkg::ST_IDLE;
      end
    endcase
    grant_d = '0;
    if (state_q == pstb_pkg::ST_RUN && !ioRefresh) begin
      grant_d[cat_q] = 1'b1;
    end
    busy_d = (state_d != pstb_pkg::ST_IDLE);
  end

  // Grant lags state by one cycle at both ends, so width is exact
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      state_q <= pstb_pkg::ST_IDLE;
      cat_q <= '0;
      win_q <= '0;
      el_q <= '0;
      grant_q <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cat_q <= cat_d;
      win_q <= win_d;
      el_q <= el_d;
      grant_q <= grant_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign svcGrant = grant_q;
  assign svcBusy = busy_q;
  assign svcDone = done_q;
  assign prevCycleTime = prevCycle_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_prevMeasure;
    cycleStart |=> prevCycle_q == $past(cycTicks_q);
  endproperty
  a_prevMeasure: assert property (p_prevMeasure)
    else $error("previous cycle time not captured at cycle start");

  property p_noRefreshGrant;
    ioRefresh |=> grant_q == '0;
  endproperty
  a_noRefreshGrant: assert property (p_noRefreshGrant)
    else $error("grant held during I/O refresh");

  property p_zeroCat(int idx);
    (state_q == pstb_pkg::ST_SELECT && cat_q == CATW'(idx) && !$past(catActive[idx]))
      |=> state_q != pstb_pkg::ST_ALIGN;
  endproperty
  a_zeroUnit: assert property (p_zeroCat(`PSTB_CAT_UNIT))
    else $error("unit category opened a window with no units");
  a_zeroPort: assert property (p_zeroCat(`PSTB_CAT_PORT))
    else $error("port category opened a window with nothing connected");
  a_zeroComm: assert property (p_zeroCat(`PSTB_CAT_COMM))
    else $error("comm category opened a window with no ports used");
  a_zeroStor: assert property (p_zeroCat(`PSTB_CAT_STOR))
    else $error("storage category opened a window with no access");

  property p_oneGrant;
    $onehot0(grant_q);
  endproperty
  a_oneGrant: assert property (p_oneGrant)
    else $error("more than one category granted at once");

  property p_winEnd;
    (state_q == pstb_pkg::ST_RUN && tick && !ioRefresh && el_q + CW'(1) == win_q)
      |=> state_q inside {pstb_pkg::ST_SELECT, pstb_pkg::ST_IDLE} ##1 grant_q == '0;
  endproperty
  a_winEnd: assert property (p_winEnd)
    else $error("window did not end when budget reached");

  property p_winHold;
    (state_q == pstb_pkg::ST_RUN && !tick) |=> state_q == pstb_pkg::ST_RUN;
  endproperty
  a_winHold: assert property (p_winHold)
    else $error("window ended between ticks");

  property p_elBound;
    state_q == pstb_pkg::ST_RUN |-> el_q < win_q;
  endproperty
  a_elBound: assert property (p_elBound)
    else $error("elapsed time passed the window budget");

  c_phaseDone: cover property (servStart && !busy_q ##[1:1000] done_q);
  c_refreshPause: cover property (state_q == pstb_pkg::ST_RUN && ioRefresh);
  c_skip: cover property (state_q == pstb_pkg::ST_SELECT && budget[cat_q] == '0);
endmodule : pstb_top

// [dv/pstb_top_tb.sv]
// Self-checking bench of the peripheral servicing time budget block
`timescale 1ns/1ps
`include "pstb_defines.svh"
module pstb_top_tb;
  // ==========================================================================
  // Stimulus and observed signals
  logic core_clk;
  logic rst_b;
  logic cycleStart;
  logic servStart;
  logic ioRefresh;
  logic [`PSTB_NCAT-1:0] catActive;
  logic [`PSTB_NCAT-1:0] uniformEn;
  logic [`PSTB_NCAT-1:0][15:0] uniformTime;
  logic [`PSTB_NCAT-1:0] svcGrant;
  logic svcBusy;
  logic svcDone;
  logic [31:0] prevCycleTime;
  int nMismatch;
  int comparisons;

  // Device under test
  pstb_top #(.CW(32), .UW(16)) dut_u (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .cycleStart(cycleStart),
    .servStart(servStart),
    .ioRefresh(ioRefresh),
    .catActive(catActive),
    .uniformEn(uniformEn),
    .uniformTime(uniformTime),
    .svcGrant(svcGrant),
    .svcBusy(svcBusy),
    .svcDone(svcDone),
    .prevCycleTime(prevCycleTime)
  );

  // 20 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic end_of_test();
    $display("comparisons=%0d mismatches=%0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      nMismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Inputs change and outputs are read 2 ns after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #2;
  endtask : tick

  // One servicing phase; counts grant cycles per category
  task automatic run_phase(output int cnt[4], output int doneAt);
    int k;
    cnt = '{0, 0, 0, 0};
    doneAt = -1;
    servStart = 1'b1;
    tick(1);
    servStart = 1'b0;
    for (k = 1; k < 20000 && doneAt < 0; k++) begin
      for (int i = 0; i < 4; i++) if (svcGrant[i] === 1'b1) cnt[i]++;
      if (svcDone === 1'b1) doneAt = k;
      tick(1);
    end
    if (doneAt < 0) begin
      nMismatch++;
      end_of_test();
    end
  endtask : run_phase

  // ==========================================================================
  // Scenarios
  task automatic t_none();
    int cnt[4];
    int d;
    catActive = 4'h0;
    uniformEn = 4'hf;
    tick(3);
    run_phase(cnt, d);
    for (int i = 0; i < 4; i++) chk(cnt[i], 32'h0);
    chk(d, 32'h5);
  endtask : t_none

  task automatic t_uniform();
    int cnt[4];
    int d;
    // Inactive category with a uniform time set must still be skipped
    catActive = 4'ha;
    uniformEn = 4'hb;
    uniformTime[0] = 16'h0003;
    uniformTime[1] = 16'h0002;
    uniformTime[3] = 16'h0001;
    tick(3);
    run_phase(cnt, d);
    chk(cnt[0], 32'h0);
    chk(cnt[1], 32'h0fa0);
    chk(cnt[2], 32'h0);
    chk(cnt[3], 32'h07d0);
    tick(1);
    chk(svcBusy, 1'b0);
  endtask : t_uniform

  task automatic t_floor();
    int cnt[4];
    int d;
    // Twenty-five ticks of cycle time: four percent is exactly one tick
    cycleStart = 1'b1;
    tick(1);
    cycleStart = 1'b0;
    tick(49999);
    cycleStart = 1'b1;
    tick(1);
    cycleStart = 1'b0;
    tick(1);
    chk(prevCycleTime, 32'h19);
    catActive = 4'h5;
    uniformEn = 4'h4;
    uniformTime[2] = 16'h0000;
    tick(3);
    run_phase(cnt, d);
    chk(cnt[0], 32'h07d0);
    chk(cnt[2], 32'h07d0);
  endtask : t_floor

  task automatic t_refresh();
    int k;
    catActive = 4'h4;
    uniformEn = 4'h4;
    uniformTime[2] = 16'h0001;
    tick(3);
    servStart = 1'b1;
    tick(1);
    servStart = 1'b0;
    for (k = 0; k < 3000 && svcGrant[2] !== 1'b1; k++) tick(1);
    chk(svcGrant[2], 1'b1);
    if (k == 3000) end_of_test();
    ioRefresh = 1'b1;
    tick(2);
    chk(svcGrant, 4'h0);
    // Longer than the whole budget; the window must survive it
    tick(2500);
    chk(svcGrant, 4'h0);
    chk(svcBusy, 1'b1);
    ioRefresh = 1'b0;
    // A start while busy is ignored
    servStart = 1'b1;
    tick(1);
    servStart = 1'b0;
    for (k = 0; k < 6000 && svcDone !== 1'b1; k++) tick(1);
    chk(svcDone, 1'b1);
    if (k == 6000) end_of_test();
    tick(3);
    chk(svcBusy, 1'b0);
  endtask : t_refresh

  // ==========================================================================
  // Main sequence
  initial begin
    nMismatch = 0;
    comparisons = 0;
    rst_b = 1'b0;
    cycleStart = 1'b0;
    servStart = 1'b0;
    ioRefresh = 1'b0;
    catActive = 4'h0;
    uniformEn = 4'h0;
    uniformTime = '0;
    tick(2);
    chk({svcGrant, svcBusy, svcDone}, 32'h0);
    chk(prevCycleTime, 32'h0);
    rst_b = 1'b1;
    t_none();
    t_uniform();
    t_floor();
    t_refresh();
    end_of_test();
  end
endmodule : pstb_top_tb
